// ===== logic/emu_gating_defines.vh
`ifndef EMU_GATING_DEFINES_VH
`define EMU_GATING_DEFINES_VH

// wishbone word offsets (byte addresses)
`define OFF_COMMAND      8'h00
`define OFF_MASK         8'h04
`define OFF_STATUS       8'h08
`define OFF_IRQ_EDGE     8'h0c
`define OFF_IRQ_PENDING  8'h10
`define OFF_TX_HOLD      8'h14
`define OFF_PORT_OUT     8'h18
`define OFF_PORT_DIR     8'h1c
`define OFF_PORT_IN      8'h20
`define OFF_WAIT_CFG     8'h24

// command register codes, bits [1:0]
`define CMD_RUN          2'h1
`define CMD_BREAK        2'h2
`define CMD_STEP         2'h3
// command register bit 4: debugger cpu reset
`define CMD_CPU_RESET_BIT 4

// mask register bits
`define MASK_RESET_BIT   0
`define MASK_NMI_BIT     1
`define MASK_STANDBY_BIT 2
`define MASK_RESET_VALUE 3'h4

// wait configuration reset value (programmed wait states)
`define WAIT_CFG_RESET   4'h0

// register values loaded at power-on initialisation
`define GENERAL_REG_INIT 32'h00000000
`define STACK_PTR_INIT   32'h000fff10
`define COND_CODE_IMASK_BIT 7

`endif

// ===== logic/emu_sync2.v
`timescale 1ns/100ps
module emu_sync2 #(
   parameter             WIDTH     = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input  wire             core_clk,
   input  wire             rst_n,
   // data
   input  wire [WIDTH-1:0] asyncIn,
   output reg  [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1;

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1  <= RESET_VAL;
         syncOut <= RESET_VAL;
      end
      else
      begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end

endmodule // emu_sync2

// ===== logic/emu_irq_gate.v
`timescale 1ns/100ps
module emu_irq_gate #(
   parameter NUM_IRQ = 8
) (
   // clock and reset
   input  wire               core_clk,
   input  wire               rst_n,
   // synchronised requests and configuration
   input  wire [NUM_IRQ-1:0] irqSync,
   input  wire [NUM_IRQ-1:0] edgeMode,
   input  wire               deliverEn,
   // cpu side
   input  wire [NUM_IRQ-1:0] irqAck,
   output wire [NUM_IRQ-1:0] irqToCpu,
   output wire [NUM_IRQ-1:0] pending
);

   reg [NUM_IRQ-1:0] irqPrev;
   reg [NUM_IRQ-1:0] latched;

   genvar i;
   generate
      for (i = 0; i < NUM_IRQ; i = i + 1)
      begin : gIrq
         wire rise = irqSync[i] & ~irqPrev[i];

         always @(posedge core_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               irqPrev[i] <= 1'b0;
               latched[i] <= 1'b0;
            end
            else
            begin
               irqPrev[i] <= irqSync[i];
               // edges are caught in any state; a new edge beats the ack
               if (edgeMode[i] && rise)
                  latched[i] <= 1'b1;
               else if (irqAck[i] || !edgeMode[i])
                  latched[i] <= 1'b0;
            end
         end

         // level requests seen in break are simply dropped
         assign irqToCpu[i] = deliverEn &
                              (edgeMode[i] ? latched[i] : irqSync[i]);
         assign pending[i]  = latched[i];
      end
   endgenerate

endmodule // emu_irq_gate

// ===== logic/emu_break_gating.v
`timescale 1ns/100ps
`include "emu_gating_defines.vh"

// Functional notes
// - an interrupt arriving in break mode is not delivered to the processor.
// - an edge interrupt seen in break is latched and delivered after the next run command.
// - every interrupt request is masked while a single step executes.
// - external reset, nmi and standby inputs each have a host mask, standby masked by default.
// - the external reset input acts only in run mode.
// - the watchdog counter counts only in run mode, halting at each break.
// - the multi-channel timer and pattern output unit run in every state.
// - the serial port runs in break and run, and a host transmit write restarts its output.
// - the dma unit serves transfer requests in both run and break.
// - programmed waits apply to all memory, the wait pin only to target memory and refresh cycles.
// - the wait pin is always honoured during refresh cycles.
// - port pins work in all states and the host can read and write them.
// - the refresh controller runs continuously, with no battery backup mode.
// - power-on init loads pc from the vector, clears general regs and sets the stack pointer.
// - power-on init and debugger cpu reset both set the condition code interrupt mask bit.
// - unmasked standby initialises the emulator and its release starts a power-on reset.
module emu_break_gating #(
   parameter NUM_IRQ   = 8,
   parameter PORT_BITS = 8
) (
   // clock and reset
   input  wire                 core_clk,
   input  wire                 rst_n,
   // wishbone slave
   input  wire                 wb_cyc_i,
   input  wire                 wb_stb_i,
   input  wire                 wb_we_i,
   input  wire [7:0]           wb_adr_i,
   input  wire [3:0]           wb_sel_i,
   input  wire [31:0]          wb_dat_i,
   output reg  [31:0]          wb_dat_o,
   output wire                 wb_ack_o,
   // target control pins, active low
   input  wire                 externalResetIn_n,
   input  wire                 nmiIn_n,
   input  wire                 standbyIn_n,
   // target interrupt pins
   input  wire [NUM_IRQ-1:0]   irqIn,
   // emulated cpu interface
   input  wire                 breakReq,
   input  wire                 stepDone,
   input  wire [NUM_IRQ-1:0]   irqAck,
   output wire [NUM_IRQ-1:0]   irqToCpu,
   output wire                 nmiToCpu,
   output wire                 cpuRunEn,
   output reg                  cpuResetOut,
   output reg                  pcLoadVector,
   output reg                  generalRegsLoad,
   output wire [31:0]          generalRegsInit,
   output reg                  stackPointerLoad,
   output wire [31:0]          stackPointerInit,
   output reg                  condCodeMaskSet,
   output wire [7:0]           condCodeMaskBits,
   output reg                  peripheralInit,
   // peripheral enables
   output wire                 watchdogCountEn,
   output wire                 timerRunEn,
   output wire                 patternRunEn,
   output wire                 serialRunEn,
   output wire                 dmaRunEn,
   output wire                 refreshRunEn,
   // serial port host access
   output reg                  serialReinit,
   output reg  [7:0]           serialTxData,
   // port pins
   input  wire [PORT_BITS-1:0] portIn,
   output reg  [PORT_BITS-1:0] portOut,
   output reg  [PORT_BITS-1:0] portOe,
   // memory wait control
   input  wire                 memCycle,
   input  wire                 targetAccess,
   input  wire                 refreshCycle,
   input  wire                 waitIn_n,
   output wire                 memReady
);

   localparam ST_BREAK = 2'h0;
   localparam ST_RUN   = 2'h1;
   localparam ST_STEP  = 2'h2;

   reg  [1:0]           state;
   reg  [1:0]           next_state;
   reg                  ackReg;
   reg  [2:0]           maskBits;
   reg  [NUM_IRQ-1:0]   edgeMode;
   reg  [3:0]           waitStates;
   reg  [3:0]           waitCount;
   reg                  initPending;
   reg                  standbyHeld;
   reg                  cpuResetCmd;
   wire                 resetSync_n;
   wire                 nmiSync_n;
   wire                 standbySync_n;
   wire                 waitSync_n;
   wire [NUM_IRQ-1:0]   irqSync;
   wire [PORT_BITS-1:0] portSync;
   wire [NUM_IRQ-1:0]   irqPending;
   wire                 busReq;
   wire                 busWrite;
   wire                 lowLane;
   wire                 standbyActive;
   wire                 targetResetActive;
   wire                 runCmd;
   wire                 breakCmd;
   wire                 stepCmd;
   wire                 waitPinApplies;

   // pins cross domains; flops reset to each pin's idle level, so no false assertion
   emu_sync2 #(.WIDTH(4 + NUM_IRQ + PORT_BITS),
               .RESET_VAL({4'hf, {(NUM_IRQ + PORT_BITS){1'b0}}})) uSync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .asyncIn  ({externalResetIn_n, nmiIn_n, standbyIn_n, waitIn_n, irqIn, portIn}),
      .syncOut  ({resetSync_n, nmiSync_n, standbySync_n, waitSync_n, irqSync, portSync})
   );

   // bus decode
   assign busReq   = wb_cyc_i & wb_stb_i & ~ackReg;
   assign busWrite = busReq & wb_we_i;
   assign lowLane  = wb_sel_i[0];
   assign wb_ack_o = ackReg;

   assign runCmd   = busWrite && lowLane && (wb_adr_i == `OFF_COMMAND) &&
                     (wb_dat_i[1:0] == `CMD_RUN);
   assign breakCmd = busWrite && lowLane && (wb_adr_i == `OFF_COMMAND) &&
                     (wb_dat_i[1:0] == `CMD_BREAK);
   assign stepCmd  = busWrite && lowLane && (wb_adr_i == `OFF_COMMAND) &&
                     (wb_dat_i[1:0] == `CMD_STEP);

   assign standbyActive     = ~standbySync_n & ~maskBits[`MASK_STANDBY_BIT];
   assign targetResetActive = ~resetSync_n & ~maskBits[`MASK_RESET_BIT] &
                              (state == ST_RUN);

   // single execution state
   always @*
   begin
      next_state = state;
      case (state)
         ST_BREAK:
         begin
            if (runCmd)
               next_state = ST_RUN;
            else if (stepCmd)
               next_state = ST_STEP;
         end
         ST_RUN:
         begin
            if (breakCmd || breakReq)
               next_state = ST_BREAK;
         end
         ST_STEP:
         begin
            if (stepDone || breakCmd)
               next_state = ST_BREAK;
         end
         default:
            next_state = ST_BREAK;
      endcase
      // standby and init hold the processor stopped
      if (standbyActive || standbyHeld || initPending)
         next_state = ST_BREAK;
   end

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= ST_BREAK;
      else
         state <= next_state;
   end

   assign cpuRunEn = (state == ST_RUN) || (state == ST_STEP);
   // interrupts delivered only in run; step and break mask them
   emu_irq_gate #(.NUM_IRQ(NUM_IRQ)) uIrq (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .irqSync   (irqSync),
      .edgeMode  (edgeMode),
      .deliverEn (state == ST_RUN),
      .irqAck    (irqAck),
      .irqToCpu  (irqToCpu),
      .pending   (irqPending)
   );

   assign nmiToCpu = ~nmiSync_n & ~maskBits[`MASK_NMI_BIT] & (state == ST_RUN);

   // peripheral gating
   assign watchdogCountEn = (state == ST_RUN);
   assign timerRunEn      = 1'b1;
   assign patternRunEn    = 1'b1;
   assign serialRunEn     = 1'b1;
   assign dmaRunEn        = 1'b1;
   assign refreshRunEn    = 1'b1;

   // constant init values; a debugger reset leaves regs alone
   assign generalRegsInit  = `GENERAL_REG_INIT;
   assign stackPointerInit = `STACK_PTR_INIT;
   assign condCodeMaskBits = 8'h01 << `COND_CODE_IMASK_BIT;

   // wait control: pin is ignored for emulation memory
   assign waitPinApplies = targetAccess | refreshCycle;
   assign memReady = memCycle && (waitCount >= waitStates) &&
                     !(waitPinApplies && !waitSync_n);

   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         waitCount <= 4'h0;
      else if (!memCycle)
         waitCount <= 4'h0;
      else if (waitCount < waitStates)
         waitCount <= waitCount + 4'h1;
   end

   // initialisation sequencing
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         initPending      <= 1'b1;
         standbyHeld      <= 1'b0;
         cpuResetCmd      <= 1'b0;
         cpuResetOut      <= 1'b0;
         pcLoadVector     <= 1'b0;
         generalRegsLoad  <= 1'b0;
         stackPointerLoad <= 1'b0;
         condCodeMaskSet  <= 1'b0;
         peripheralInit   <= 1'b0;
      end
      else
      begin
         cpuResetCmd <= busWrite && lowLane && (wb_adr_i == `OFF_COMMAND) &&
                        wb_dat_i[`CMD_CPU_RESET_BIT];
         standbyHeld <= standbyActive;
         // standby release re-arms a full power-on init
         if (standbyHeld && !standbyActive)
            initPending <= 1'b1;
         else if (initPending && !standbyActive)
            initPending <= 1'b0;
         peripheralInit   <= standbyActive;
         cpuResetOut      <= standbyActive || initPending || targetResetActive;
         pcLoadVector     <= (initPending && !standbyActive) || cpuResetCmd ||
                             targetResetActive;
         generalRegsLoad  <= initPending && !standbyActive;
         stackPointerLoad <= initPending && !standbyActive;
         condCodeMaskSet  <= (initPending && !standbyActive) || cpuResetCmd ||
                             targetResetActive;
      end
   end

   // register writes
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         maskBits     <= `MASK_RESET_VALUE;
         edgeMode     <= {NUM_IRQ{1'b0}};
         waitStates   <= `WAIT_CFG_RESET;
         serialReinit <= 1'b0;
         serialTxData <= 8'h00;
         portOut      <= {PORT_BITS{1'b0}};
         portOe       <= {PORT_BITS{1'b0}};
      end
      else
      begin
         serialReinit <= 1'b0;
         if (standbyActive)
         begin
            edgeMode   <= {NUM_IRQ{1'b0}};
            waitStates <= `WAIT_CFG_RESET;
         end
         else if (standbyHeld)
            maskBits <= `MASK_RESET_VALUE;
         else if (busWrite && lowLane)
         begin
            if (wb_adr_i == `OFF_MASK)
               maskBits <= wb_dat_i[2:0];
            else if (wb_adr_i == `OFF_IRQ_EDGE)
               edgeMode <= wb_dat_i[NUM_IRQ-1:0];
            else if (wb_adr_i == `OFF_TX_HOLD)
            begin
               serialTxData <= wb_dat_i[7:0];
               serialReinit <= 1'b1;
            end
            else if (wb_adr_i == `OFF_PORT_OUT)
               portOut <= wb_dat_i[PORT_BITS-1:0];
            else if (wb_adr_i == `OFF_PORT_DIR)
               portOe <= wb_dat_i[PORT_BITS-1:0];
            else if (wb_adr_i == `OFF_WAIT_CFG)
               waitStates <= wb_dat_i[3:0];
         end
      end
   end

   // read path and ack, unmapped reads give zero
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ackReg   <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         ackReg <= busReq;
         if (busReq && !wb_we_i)
         begin
            if (wb_adr_i == `OFF_COMMAND)
               wb_dat_o <= {30'h00000000, state};
            else if (wb_adr_i == `OFF_MASK)
               wb_dat_o <= {29'h00000000, maskBits};
            else if (wb_adr_i == `OFF_STATUS)
               wb_dat_o <= {26'h0000000, ~waitSync_n, ~nmiSync_n, ~resetSync_n,
                            standbyActive, state};
            else if (wb_adr_i == `OFF_IRQ_EDGE)
               wb_dat_o <= {{(32-NUM_IRQ){1'b0}}, edgeMode};
            else if (wb_adr_i == `OFF_IRQ_PENDING)
               wb_dat_o <= {{(32-NUM_IRQ){1'b0}}, irqPending};
            else if (wb_adr_i == `OFF_TX_HOLD)
               wb_dat_o <= {24'h000000, serialTxData};
            else if (wb_adr_i == `OFF_PORT_OUT)
               wb_dat_o <= {{(32-PORT_BITS){1'b0}}, portOut};
            else if (wb_adr_i == `OFF_PORT_DIR)
               wb_dat_o <= {{(32-PORT_BITS){1'b0}}, portOe};
            else if (wb_adr_i == `OFF_PORT_IN)
               wb_dat_o <= {{(32-PORT_BITS){1'b0}}, portSync};
            else if (wb_adr_i == `OFF_WAIT_CFG)
               wb_dat_o <= {28'h0000000, waitStates};
            else
               wb_dat_o <= 32'h00000000;
         end
      end
   end

endmodule // emu_break_gating

// ===== tb/emu_cpu_model.sv
`timescale 1ns/100ps
module emu_cpu_model #(
   parameter NUM_IRQ = 8
) (
   // clock and reset
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   // cpu side of the gating block
   input  wire logic [NUM_IRQ-1:0] irqToCpu,
   input  wire logic               cpuRunEn,
   input  wire logic               watchdogCountEn,
   output logic      [NUM_IRQ-1:0] irqAck,
   output logic                    stepDone
);
   int ackWait;
   int stepWait;

   // slow acceptance, so a delivered request stays visible for a few cycles
   always @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irqAck   <= '0;
         stepDone <= 1'b0;
         ackWait  <= 0;
         stepWait <= 0;
      end
      else
      begin
         irqAck   <= '0;
         stepDone <= 1'b0;
         ackWait  <= (irqToCpu != '0 && ackWait < 3) ? ackWait + 1 : 0;
         if (ackWait == 3)
            irqAck <= irqToCpu;
         // step: running without the watchdog counting
         stepWait <= (cpuRunEn && !watchdogCountEn && !stepDone) ? stepWait + 1 : 0;
         if (stepWait == 2)
            stepDone <= 1'b1;
      end
   end
endmodule // emu_cpu_model

// ===== tb/emu_break_gating_sva.sv
`timescale 1ns/100ps
module emu_break_gating_sva #(
   parameter NUM_IRQ = 8
) (
   input wire logic               core_clk,
   input wire logic               rst_n,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_ack_o,
   input wire logic [NUM_IRQ-1:0] irqToCpu,
   input wire logic               nmiToCpu,
   input wire logic               cpuRunEn,
   input wire logic               watchdogCountEn,
   input wire logic               timerRunEn,
   input wire logic               patternRunEn,
   input wire logic               serialRunEn,
   input wire logic               dmaRunEn,
   input wire logic               refreshRunEn,
   input wire logic               pcLoadVector,
   input wire logic               generalRegsLoad,
   input wire logic               stackPointerLoad,
   input wire logic               condCodeMaskSet,
   input wire logic [31:0]        generalRegsInit,
   input wire logic [31:0]        stackPointerInit,
   input wire logic [7:0]         condCodeMaskBits,
   input wire logic               memCycle,
   input wire logic               targetAccess,
   input wire logic               refreshCycle,
   input wire logic               waitIn_n,
   input wire logic               memReady
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_irq_not_run: assert property (!watchdogCountEn |-> irqToCpu == '0 && !nmiToCpu)
      else $error("interrupt delivered outside run");
   a_wdog_run_only: assert property (watchdogCountEn |-> cpuRunEn)
      else $error("watchdog counting while cpu stopped");
   a_timer_always: assert property (timerRunEn && patternRunEn)
      else $error("timer or pattern unit stopped");
   a_serial_dma_on: assert property (serialRunEn && dmaRunEn)
      else $error("serial or dma unit stopped");
   a_refresh_on: assert property (refreshRunEn)
      else $error("refresh stopped");
   a_wait_pin_held: assert property (
      !$past(waitIn_n, 1) && !$past(waitIn_n, 2) && !$past(waitIn_n, 3)
      && (targetAccess || refreshCycle) |-> !memReady)
      else $error("wait pin ignored");
   a_ready_in_cycle: assert property (memReady |-> memCycle)
      else $error("ready outside memory cycle");
   a_init_load: assert property (
      $rose(rst_n) |=> pcLoadVector && generalRegsLoad && stackPointerLoad && condCodeMaskSet
      && generalRegsInit == 32'h0 && stackPointerInit == 32'h000fff10 && condCodeMaskBits[7])
      else $error("power-on load missing");
   a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not one cycle");
endmodule // emu_break_gating_sva

bind emu_break_gating emu_break_gating_sva #(.NUM_IRQ(NUM_IRQ)) emu_break_gating_sva_i (.*);

// ===== tb/tb_emu_break_gating.sv
`timescale 1ns/100ps
`include "emu_gating_defines.vh"
module tb_emu_break_gating;
   logic        core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i, irqIn, irqAck, irqToCpu, condCodeMaskBits, serialTxData;
   logic [7:0]  portIn, portOut, portOe;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, generalRegsInit, stackPointerInit, d;
   logic        externalResetIn_n, nmiIn_n, standbyIn_n, breakReq, stepDone, nmiToCpu;
   logic        cpuRunEn, cpuResetOut, pcLoadVector, generalRegsLoad, stackPointerLoad;
   logic        condCodeMaskSet, peripheralInit, watchdogCountEn, timerRunEn, patternRunEn;
   logic        serialRunEn, dmaRunEn, refreshRunEn, serialReinit, memReady, seen;
   logic        memCycle, targetAccess, refreshCycle, waitIn_n;
   int          nMismatch, testsRun, cycles;

   emu_break_gating emu_break_gating_i (.*);
   emu_cpu_model emu_cpu_model_i (.*);

   initial
   begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         nMismatch++;
         conclude();
      end
   end

   task conclude();
      if (nMismatch == 0 && testsRun > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      testsRun++;
      if (g !== e)
      begin
         nMismatch++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   // held until ack is seen, released on the edge that samples it
   task wbx(input logic we, input logic [7:0] a, input logic [31:0] w, output logic [31:0] r);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= w;
      do
         @(posedge core_clk);
      while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task wbw(input logic [7:0] a, input logic [31:0] w);
      logic [31:0] x;
      wbx(1'b1, a, w, x);
   endtask

   initial
   begin
      {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, breakReq, memCycle, targetAccess, refreshCycle} = '0;
      {wb_adr_i, irqIn, wb_dat_i, portIn} = '0;
      wb_sel_i = 4'hf;
      {externalResetIn_n, nmiIn_n, standbyIn_n, waitIn_n} = 4'hf;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      cyc(3);
      wbx(0, `OFF_MASK, 0, d); chk("mask reset", 32'h4, d);
      wbx(0, `OFF_STATUS, 0, d); chk("state", 32'h0, d & 32'h3);
      wbx(0, 8'hfc, 0, d); chk("unmapped", 32'h0, d);
      wbw(`OFF_IRQ_EDGE, 32'h1);
      irqIn <= 8'h03;
      cyc(6);
      chk("irq in break", 32'h0, irqToCpu);
      wbx(0, `OFF_IRQ_PENDING, 0, d); chk("pending", 32'h1, d);
      irqIn <= 8'h02;
      wbw(`OFF_COMMAND, `CMD_RUN);
      chk("irq on run", 32'h3, irqToCpu);
      chk("wdog run", 32'h1, watchdogCountEn);
      cyc(6);
      wbx(0, `OFF_IRQ_PENDING, 0, d); chk("pending acked", 32'h0, d);
      breakReq <= 1'b1;
      cyc(2);
      breakReq <= 1'b0;
      chk("wdog break", 32'h0, watchdogCountEn);
      wbw(`OFF_COMMAND, `CMD_STEP);
      chk("step runs", 32'h1, cpuRunEn);
      chk("step irq", 32'h0, irqToCpu);
      cyc(5);
      wbx(0, `OFF_STATUS, 0, d); chk("after step", 32'h0, d & 32'h3);
      irqIn <= 8'h00;
      externalResetIn_n <= 1'b0;
      cyc(5);
      chk("reset in break", 32'h0, cpuResetOut);
      wbw(`OFF_MASK, 32'h7);
      nmiIn_n <= 1'b0;
      wbw(`OFF_COMMAND, `CMD_RUN);
      cyc(4);
      chk("nmi masked", 32'h0, nmiToCpu);
      chk("reset masked", 32'h0, cpuResetOut);
      wbw(`OFF_MASK, 32'h4);
      cyc(3);
      chk("nmi", 32'h1, nmiToCpu);
      chk("reset in run", 32'h1, cpuResetOut);
      {externalResetIn_n, nmiIn_n} <= 2'b11;
      wbw(`OFF_COMMAND, `CMD_BREAK);
      wbw(`OFF_MASK, 32'h0);
      standbyIn_n <= 1'b0;
      cyc(5);
      chk("standby init", 32'h1, peripheralInit);
      standbyIn_n <= 1'b1;
      seen = 1'b0;
      repeat (8)
      begin
         cyc(1);
         seen |= pcLoadVector;
      end
      chk("standby release", 32'h1, seen);
      wbx(0, `OFF_MASK, 0, d); chk("mask after standby", 32'h4, d);
      wbw(`OFF_COMMAND, 32'h10);
      seen = 1'b0;
      repeat (4)
      begin
         cyc(1);
         seen |= condCodeMaskSet && pcLoadVector && !generalRegsLoad && !stackPointerLoad;
      end
      chk("cpu reset mask", 32'h1, seen);
      wbw(`OFF_TX_HOLD, 32'ha5);
      seen = serialReinit;
      repeat (4)
      begin
         cyc(1);
         seen |= serialReinit;
      end
      chk("serial reinit", 32'h1, seen);
      chk("serial data", 32'ha5, serialTxData);
      wbw(`OFF_PORT_DIR, 32'hff);
      wbw(`OFF_PORT_OUT, 32'h5a);
      portIn <= 8'h3c;
      cyc(3);
      chk("port out", 32'h5a, portOut);
      chk("port oe", 32'hff, portOe);
      wbx(0, `OFF_PORT_IN, 0, d); chk("port in", 32'h3c, d);
      wbw(`OFF_WAIT_CFG, 32'h2);
      waitIn_n <= 1'b0;
      memCycle <= 1'b1;
      cyc(1);
      chk("prog wait", 32'h0, memReady);
      cyc(4);
      chk("emul ready", 32'h1, memReady);
      targetAccess <= 1'b1;
      cyc(1);
      chk("target wait", 32'h0, memReady);
      {targetAccess, refreshCycle} <= 2'b01;
      cyc(1);
      chk("refresh wait", 32'h0, memReady);
      waitIn_n <= 1'b1;
      cyc(4);
      chk("refresh ready", 32'h1, memReady);
      memCycle <= 1'b0;
      cyc(2);
      conclude();
   end
endmodule // tb_emu_break_gating
